/* core/rtcl_core.v */
// clock/calendar core: prescaler, update pulse, digit counters, nibble bus
// Notes on behaviour
// (R1) test pulse rising edge bumps selected digit
// (R2) reference outputs when write low, read high, E/F
// (R3) line 0 carries 1024 Hz, 488.3 us high
// (R4) lines 1..3: 122.1 us low per second/minute/hour
// (R5) host waits after stop before ending write
// (R6) host writes only while update output high
// (R7) writes suspended while update low, then resume; code still writes while stop is high
// (R8) code D write resets prescaler top and update
// (R9) during divider reset: update high, no counting
// (R10) after release update falls ~1 s later
// (R11) first ten prescaler stages keep running
// (R12) leap rule taken from day tens bits 2,3
// (R13) select 00,10,01,11 gives remainder 0,3,2,1
// (R14) any year accepted, leap judged on two digits
// (R15) update pulses at 1 Hz regardless of selects
// (R16) stop input high halts digit counting
// (R17) respond only with both selects high
// (R18) write strobe high loads nibble to digit
// (R19) february ends at 29 in leap year, else 28
// (R20) reference pulses replace read data on bus
`timescale 1ns/10ps
`include "rtcl_regs.vh"

module rtcl_core (
    input  wire       clock_i,
    input  wire       rst_b_i,
    input  wire       osc_input_i,
    input  wire       supply_side_select_i,
    input  wire       host_side_select_i,
    input  wire       write_i,
    input  wire       read_i,
    input  wire       address_write_i,
    input  wire       stop_i,
    input  wire       test_i,
    input  wire [3:0] nibble_bus_i,
    output reg  [3:0] nibble_bus_o,
    output wire [3:0] nibble_bus_oe_b_o,
    output reg        update_b_o,
    output wire       update_oe_b_o,
    output reg        one_sec_o
);

    reg        rst_q1;
    reg        rst_n;
    reg [11:0] pin_q1;
    reg [11:0] pin_q2;
    reg        osc_last;
    reg        test_last;
    reg [14:0] presc;
    reg [3:0]  address_nibble;
    reg [3:0]  dig [0:12];
    reg [3:0]  next_dig [0:12];
    reg [4:0]  r;
    reg        c;
    reg [4:0]  hv;
    reg [4:0]  dv;
    reg [4:0]  dim;
    reg [3:0]  mv;
    reg        pm;
    reg        day_carry;
    reg        sec_armed;
    integer    k;
    integer    j;

    wire       osc_s   = pin_q2[0];
    wire       sel_ok  = pin_q2[1] & pin_q2[2];
    wire       wr_s    = pin_q2[3];
    wire       rd_s    = pin_q2[4];
    wire       aw_s    = pin_q2[5];
    wire       stop_s  = pin_q2[6];
    wire       test_s  = pin_q2[7];
    wire [3:0] data_s  = pin_q2[11:8];

    wire osc_tick  = osc_s & ~osc_last;
    wire test_rise = test_s & ~test_last;
    wire div_reset = sel_ok & wr_s
                     & (address_nibble == `RTCL_ADDR_DIV_RESET); // (R8)
    wire [14:0] presc_inc = presc + 15'h0001;
    // (R16) (R9)
    wire count_tick = osc_tick & (presc == `RTCL_PRESC_LAST)
                      & ~div_reset & ~stop_s;
    wire digit_addr = (address_nibble <= `RTCL_ADDR_YEAR_T);
    // digits are writable outside the update window, or at any time while stop is high
    wire wr_ok = sel_ok & wr_s & digit_addr & (stop_s | update_b_o); // (R7)
    wire ref_mode = sel_ok & ~wr_s & rd_s
                    & ((address_nibble == `RTCL_ADDR_REF_E)
                    | (address_nibble == `RTCL_ADDR_REF_F)); // (R2)
    wire pulse_low = (presc < `RTCL_REF_LOW_TICKS) & ~div_reset;
    wire sec_zero  = (dig[0] == 4'h0) & (dig[1] == 4'h0);
    wire min_zero  = (dig[2] == 4'h0) & (dig[3] == 4'h0);
    // (R13) (R14)
    wire [1:0] leap_rem = 2'h0 - {dig[`RTCL_ADDR_DAY_T][`RTCL_LEAP_HI_BIT],
                                  dig[`RTCL_ADDR_DAY_T][`RTCL_LEAP_LO_BIT]};
    wire [3:0] year_mix = {dig[`RTCL_ADDR_YEAR_T][2:0], 1'b0}
                          + dig[`RTCL_ADDR_YEAR_U];
    wire leap_year = (year_mix[1:0] == leap_rem); // (R12)

    // only bit clearing is driven; a one releases the line
    assign nibble_bus_oe_b_o = nibble_bus_o;
    assign update_oe_b_o     = update_b_o;

    function [3:0] digit_max;
        input [3:0] a;
        begin
            case (a)
                4'h1, 4'h3: digit_max = 4'h5;
                4'h5:       digit_max = 4'h2;
                4'h6:       digit_max = 4'h6;
                4'h8:       digit_max = 4'h3;
                4'hA:       digit_max = 4'h1;
                default:    digit_max = 4'h9;
            endcase
        end
    endfunction

    // returns {wrapped, next value}
    function [4:0] bump;
        input [3:0] v;
        input [3:0] mx;
        begin
            if (v >= mx)
                bump = {1'b1, 4'h0};
            else
                bump = {1'b0, v + 4'h1};
        end
    endfunction

    function [3:0] tens_of;
        input [4:0] v;
        begin
            if (v >= 5'd30)
                tens_of = 4'h3;
            else if (v >= 5'd20)
                tens_of = 4'h2;
            else if (v >= 5'd10)
                tens_of = 4'h1;
            else
                tens_of = 4'h0;
        end
    endfunction

    function [3:0] units_of;
        input [4:0] v;
        reg   [4:0] t;
        begin
            t        = v - {1'b0, tens_of(v)} * 5'd10;
            units_of = t[3:0];
        end
    endfunction

    wire [3:0] cur_dig   = dig[address_nibble];
    wire [4:0] test_low  = bump({2'b00, cur_dig[1:0]},
                                digit_max(address_nibble));
    wire [4:0] test_full = bump(cur_dig, digit_max(address_nibble));

    always @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_q1    <= 12'h000;
            pin_q2    <= 12'h000;
            osc_last  <= 1'b0;
            test_last <= 1'b0;
        end else begin
            pin_q1    <= {nibble_bus_i, test_i, stop_i,
                          address_write_i, read_i, write_i,
                          host_side_select_i, supply_side_select_i,
                          osc_input_i};
            pin_q2    <= pin_q1;
            osc_last  <= osc_s;
            test_last <= test_s;
        end
    end

    // calendar advance by one second, carries rippling upward
    always @* begin
        for (k = 0; k < 13; k = k + 1)
            next_dig[k] = dig[k];
        c         = 1'b1;
        day_carry = 1'b0;
        hv  = 5'd0;
        dv  = 5'd0;
        dim = 5'd31;
        mv  = 4'h0;
        pm  = dig[`RTCL_ADDR_HOUR_T][`RTCL_HOUR_PM_BIT];
        r   = 5'h00;
        for (k = 0; k < 4; k = k + 1) begin
            if (c) begin
                r           = bump(dig[k], digit_max(k[3:0]));
                c           = r[4];
                next_dig[k] = r[3:0];
            end
        end
        if (c) begin
            hv = {3'b000, dig[`RTCL_ADDR_HOUR_T][1:0]} * 5'd10
                 + {1'b0, dig[4]};
            if (dig[`RTCL_ADDR_HOUR_T][`RTCL_HOUR_24H_BIT]) begin
                day_carry = (hv == 5'd23);
                hv        = day_carry ? 5'd0 : hv + 5'd1;
            end else if (hv == 5'd11) begin
                day_carry = pm;
                pm        = ~pm;
                hv        = 5'd12;
            end else if (hv >= 5'd12) begin
                hv = 5'd1;
            end else begin
                hv = hv + 5'd1;
            end
            next_dig[4] = units_of(hv);
            next_dig[`RTCL_ADDR_HOUR_T] =
                {dig[`RTCL_ADDR_HOUR_T][`RTCL_HOUR_24H_BIT], pm, 2'b00}
                | tens_of(hv);
        end
        if (day_carry) begin
            r = bump(dig[`RTCL_ADDR_WEEKDAY], 4'h6);
            next_dig[`RTCL_ADDR_WEEKDAY] = r[3:0];
            mv = (dig[`RTCL_ADDR_MON_T][0] ? 4'hA : 4'h0)
                 + dig[`RTCL_ADDR_MON_U];
            case (mv)
                4'h4, 4'h6, 4'h9, 4'hB: dim = 5'd30;
                4'h2: dim = leap_year ? 5'd29 : 5'd28; // (R19)
                default: dim = 5'd31;
            endcase
            dv = {3'b000, dig[`RTCL_ADDR_DAY_T][1:0]} * 5'd10
                 + {1'b0, dig[`RTCL_ADDR_DAY_U]};
            c  = (dv >= dim);
            dv = c ? 5'd1 : dv + 5'd1;
            next_dig[`RTCL_ADDR_DAY_U] = units_of(dv);
            next_dig[`RTCL_ADDR_DAY_T] =
                {dig[`RTCL_ADDR_DAY_T][3:2], 2'b00} | tens_of(dv);
            if (c) begin
                c  = (mv >= 4'hC);
                mv = c ? 4'h1 : mv + 4'h1;
                next_dig[`RTCL_ADDR_MON_U] = units_of({1'b0, mv});
                next_dig[`RTCL_ADDR_MON_T] = tens_of({1'b0, mv});
            end
            if (c) begin
                r = bump(dig[`RTCL_ADDR_YEAR_U], 4'h9);
                next_dig[`RTCL_ADDR_YEAR_U] = r[3:0];
                if (r[4]) begin
                    r = bump(dig[`RTCL_ADDR_YEAR_T], 4'h9);
                    next_dig[`RTCL_ADDR_YEAR_T] = r[3:0];
                end
            end
        end
    end

    // prescaler and update pulse
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            presc      <= 15'h0000;
            update_b_o <= 1'b1;
            one_sec_o  <= 1'b0;
            sec_armed  <= 1'b0;
        end else begin
            if (osc_tick)
                presc[`RTCL_PRESC_KEPT-1:0] <=
                    presc_inc[`RTCL_PRESC_KEPT-1:0]; // (R11)
            if (div_reset) begin
                presc[14:`RTCL_PRESC_KEPT] <= 5'h00; // (R8)
                update_b_o <= 1'b1; // (R9)
                one_sec_o  <= 1'b0; // (R9)
                sec_armed  <= 1'b0; // (R9)
            end else begin
                if (osc_tick)
                    presc[14:`RTCL_PRESC_KEPT] <=
                        presc_inc[14:`RTCL_PRESC_KEPT];
                // falls 8 ticks ahead of the one-second edge
                if (osc_tick && presc_inc == `RTCL_UPD_FALL)
                    update_b_o <= 1'b0; // (R10) (R15)
                else if (osc_tick && presc_inc == `RTCL_UPD_RISE)
                    update_b_o <= 1'b1; // (R15)
                // armed at the first wrap, so no early rise after a reset
                if (osc_tick && presc == `RTCL_PRESC_LAST)
                    sec_armed <= 1'b1;
                one_sec_o <= ~presc[14] & sec_armed; // (R10)
            end
        end
    end

    // address latch and digit store
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            address_nibble <= `RTCL_ADDR_SEC_U;
            for (j = 0; j < 13; j = j + 1)
                dig[j] <= `RTCL_DIGIT_RESET;
            dig[`RTCL_ADDR_DAY_U] <= `RTCL_DATE_RESET;
            dig[`RTCL_ADDR_MON_U] <= `RTCL_DATE_RESET;
        end else begin
            if (sel_ok && aw_s)
                address_nibble <= data_s; // (R17)
            if (wr_ok) begin
                // setting 24-hour mode clears the pm flag
                if (address_nibble == `RTCL_ADDR_HOUR_T
                    && data_s[`RTCL_HOUR_24H_BIT])
                    dig[address_nibble] <= {data_s[3], 1'b0,
                                            data_s[1:0]}; // (R18)
                else
                    dig[address_nibble] <= data_s; // (R18) (R12)
            end else if (sel_ok && test_rise && digit_addr) begin
                // only the count field moves; mode bits are kept
                case (address_nibble)
                    `RTCL_ADDR_HOUR_T, `RTCL_ADDR_DAY_T:
                        dig[address_nibble] <= {cur_dig[3:2],
                                                test_low[1:0]}; // (R1)
                    default:
                        dig[address_nibble] <= test_full[3:0]; // (R1)
                endcase
            end else if (count_tick) begin
                for (j = 0; j < 13; j = j + 1)
                    dig[j] <= next_dig[j]; // (R16)
            end
        end
    end

    // bus drive: reference pulses take priority over read data
    always @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            nibble_bus_o <= 4'hF;
        end else if (ref_mode) begin
            nibble_bus_o <= {~(pulse_low & sec_zero & min_zero),
                             ~(pulse_low & sec_zero),
                             ~pulse_low,
                             presc[`RTCL_REF_FAST_BIT]}; // (R3) (R4) (R20)
        end else if (sel_ok && rd_s && !wr_s && digit_addr) begin
            nibble_bus_o <= dig[address_nibble];
        end else begin
            nibble_bus_o <= 4'hF;
        end
    end

endmodule // rtcl_core

/* core/rtcl_regs.vh */
// address codes, reset values and timing counts of the clock/calendar core
`ifndef RTCL_REGS_VH
`define RTCL_REGS_VH
`define RTCL_ADDR_SEC_U      4'h0
`define RTCL_ADDR_HOUR_T     4'h5
`define RTCL_ADDR_WEEKDAY    4'h6
`define RTCL_ADDR_DAY_U      4'h7
`define RTCL_ADDR_DAY_T      4'h8
`define RTCL_ADDR_MON_U      4'h9
`define RTCL_ADDR_MON_T      4'hA
`define RTCL_ADDR_YEAR_U     4'hB
`define RTCL_ADDR_YEAR_T     4'hC
`define RTCL_ADDR_DIV_RESET  4'hD
`define RTCL_ADDR_REF_E      4'hE
`define RTCL_ADDR_REF_F      4'hF
`define RTCL_HOUR_PM_BIT     2
`define RTCL_HOUR_24H_BIT    3
`define RTCL_LEAP_LO_BIT     2
`define RTCL_LEAP_HI_BIT     3
`define RTCL_DIGIT_RESET     4'h0
`define RTCL_DATE_RESET      4'h1
`define RTCL_OSC_HZ          32768
`define RTCL_PRESC_STAGES    15
`define RTCL_PRESC_KEPT      10
`define RTCL_PRESC_LAST      15'h7FFF
`define RTCL_UPD_LEAD_US     244
`define RTCL_UPD_LEAD_TICKS  15'h0008
`define RTCL_UPD_FALL        15'h7FF8
`define RTCL_UPD_RISE        15'h0008
`define RTCL_REF_LOW_US      122
`define RTCL_REF_LOW_TICKS   15'h0004
`define RTCL_REF_FAST_BIT    4
`endif

/* bench/rtcl_props.sv */
// assertion checker watching the clock/calendar core ports
`timescale 1ns/10ps
module rtcl_props (
    input wire logic       clock_i,
    input wire logic       rst_b_i,
    input wire logic       osc_input_i,
    input wire logic       supply_side_select_i,
    input wire logic       host_side_select_i,
    input wire logic       write_i,
    input wire logic [3:0] nibble_bus_o,
    input wire logic [3:0] nibble_bus_oe_b_o,
    input wire logic       update_b_o,
    input wire logic       update_oe_b_o,
    input wire logic       one_sec_o
);
    logic [3:0] since_wr;
    logic [3:0] since_osc;
    logic       osc_q;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // a divider reset may legally force the update line, so quiet spells only
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            since_wr  <= 4'h0;
            since_osc <= 4'hF;
            osc_q     <= 1'b0;
        end else begin
            osc_q    <= osc_input_i;
            since_wr <= write_i ? 4'h0 : since_wr + {3'h0, since_wr != 4'hF};
            since_osc <= (osc_input_i && !osc_q) ? 4'h0
                       : since_osc + {3'h0, since_osc != 4'hF};
        end
    end
    a_bus_oe_mirror:
        assert property (nibble_bus_oe_b_o == nibble_bus_o)
        else $error("bus enable differs from bus data");
    a_busy_oe_mirror:
        assert property (update_oe_b_o == update_b_o)
        else $error("update enable differs from update line");
    a_reset_idle:
        assert property ($rose(rst_b_i) |-> update_b_o && !one_sec_o
                         && nibble_bus_o == 4'hF)
        else $error("outputs not idle at reset release");
    a_select_release:
        assert property ((!(supply_side_select_i && host_side_select_i))[*5]
                         |-> nibble_bus_o == 4'hF)
        else $error("bus driven while deselected");
    a_busy_low_width:
        assert property ($fell(update_b_o) && since_wr == 4'hF
                         |-> (!update_b_o)[*8])
        else $error("update pulse too short");
    a_busy_osc_paced:
        assert property ($fell(update_b_o) |-> since_osc <= 4'h7)
        else $error("update fell without oscillator tick");
    a_sec_low_at_fall:
        assert property ($fell(update_b_o) |-> !one_sec_o)
        else $error("one second high when update fell");
    a_sec_in_busy:
        assert property ($rose(one_sec_o) && since_wr == 4'hF |-> !update_b_o)
        else $error("one second rose outside update pulse");
    a_rise_with_sec:
        assert property ($rose(update_b_o) && since_wr == 4'hF |-> one_sec_o)
        else $error("update ended before one second rose");
    c_busy_fall: cover property ($fell(update_b_o));
    c_sec_rise: cover property ($rose(one_sec_o));
    c_bus_low: cover property (!nibble_bus_o[0]);
endmodule // rtcl_props

bind rtcl_core rtcl_props u_props (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .osc_input_i(osc_input_i),
    .supply_side_select_i(supply_side_select_i),
    .host_side_select_i(host_side_select_i), .write_i(write_i),
    .nibble_bus_o(nibble_bus_o), .nibble_bus_oe_b_o(nibble_bus_oe_b_o),
    .update_b_o(update_b_o), .update_oe_b_o(update_oe_b_o),
    .one_sec_o(one_sec_o)
);

/* bench/rtcl_host.sv */
// host side model: oscillator stand-in and pulled-up open-drain bus
`timescale 1ns/10ps
module rtcl_host (
    input  wire logic       clock_i,
    input  wire logic       drive_en_i,
    input  wire logic [3:0] drive_val_i,
    input  wire logic [3:0] dut_oe_b_i,
    output logic            osc_o,
    output wire logic [3:0] bus_o
);
    // fast crystal stand-in so that one full second fits in the run
    initial osc_o = 1'b0;
    always @(posedge clock_i) osc_o <= #3 ~osc_o;
    // pull-ups hold every line high unless a party pulls it low
    assign bus_o = (drive_en_i ? drive_val_i : 4'hF) & dut_oe_b_i;
endmodule // rtcl_host

/* bench/testbench.sv */
// self-checking bench for the clock/calendar core
`timescale 1ns/10ps
module testbench;
    logic       clk, rst_b, sel_ok, wr, rd, aw, stop, test, h_en, osc;
    logic       upd, sec, hsel;
    logic [3:0] h_val, bus, nbo, oe_b;
    int         err_count, n_tests, cyc, n;
    logic [3:0] vals [0:12] = '{4'h9, 4'h5, 4'h9, 4'h5, 4'h3, 4'hA, 4'h0,
                                4'h8, 4'hE, 4'h2, 4'h0, 4'h1, 4'h0};
    rtcl_core u_dut (
        .clock_i(clk), .rst_b_i(rst_b), .osc_input_i(osc),
        .supply_side_select_i(sel_ok), .host_side_select_i(hsel),
        .write_i(wr), .read_i(rd), .address_write_i(aw), .stop_i(stop),
        .test_i(test), .nibble_bus_i(bus), .nibble_bus_o(nbo),
        .nibble_bus_oe_b_o(oe_b), .update_b_o(upd), .update_oe_b_o(),
        .one_sec_o(sec));
    rtcl_host u_host (.clock_i(clk), .drive_en_i(h_en), .drive_val_i(h_val),
        .dut_oe_b_i(oe_b), .osc_o(osc), .bus_o(bus));
    initial clk = 1'b0;
    always #5 clk = ~clk;
    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // leaves the host driving the address; callers release the bus
    task automatic latch(input logic [3:0] a);
        h_en = 1'b1;
        h_val = a;
        aw = 1'b1;
        step(50);
        aw = 1'b0;
        step(10);
    endtask
    task automatic wr_digit(input logic [3:0] a, input logic [3:0] d);
        latch(a);
        h_val = d;
        wr = 1'b1;
        step(200);
        wr = 1'b0;
        h_en = 1'b0;
        step(10);
    endtask
    task automatic rd_digit(input logic [3:0] a, input logic [3:0] exp);
        latch(a);
        h_en = 1'b0;
        rd = 1'b1;
        step(100);
        check("read data", bus, exp);
        rd = 1'b0;
        step(10);
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            err_count++;
            report_and_stop;
        end
    end
    initial begin
        {rst_b, sel_ok, wr, rd, aw, stop, test, h_en} = 8'h00;
        h_val = 4'h0;
        hsel = 1'b1;
        step(4);
        rst_b = 1'b1;
        step(3);
        check("idle update", upd, 1'b1);
        check("idle one second", sec, 1'b0);
        check("idle bus", bus, 4'hF);
        sel_ok = 1'b1;
        // counting halted before any write, held well past the longest wait
        stop = 1'b1;
        step(1200);
        for (int i = 0; i < 13; i++) wr_digit(i[3:0], vals[i]);
        for (int i = 0; i < 13; i++) rd_digit(i[3:0], vals[i]);
        sel_ok = 1'b0;
        wr_digit(4'h0, 4'h1);
        sel_ok = 1'b1;
        rd_digit(4'h0, 4'h9);
        hsel = 1'b0;
        wr_digit(4'h0, 4'h2);
        hsel = 1'b1;
        rd_digit(4'h0, 4'h9);
        latch(4'h0);
        h_en = 1'b0;
        test = 1'b1;
        step(10);
        test = 1'b0;
        step(10);
        rd_digit(4'h0, 4'h0);
        wr_digit(4'h0, 4'h9);
        latch(4'hE);
        h_en = 1'b0;
        rd = 1'b1;
        step(10);
        n = 0;
        repeat (128) begin
            n += int'(nbo[0] === 1'b1);
            step(1);
        end
        check("reference line 0 high count", n[15:0], 16'd64);
        rd = 1'b0;
        step(10);
        latch(4'hD);
        wr = 1'b1;
        stop = 1'b0;
        step(10);
        check("update in divider reset", upd, 1'b1);
        check("one second in divider reset", sec, 1'b0);
        wr = 1'b0;
        h_en = 1'b0;
        n = 0;
        while (upd === 1'b1 && n < 70000) begin
            step(1);
            n++;
        end
        check("update fall delay", n >= 63400 && n <= 65540, 1'b1);
        n = 0;
        while (upd !== 1'b1 && n < 100) begin
            step(1);
            n++;
        end
        check("update low width", n < 100, 1'b1);
        stop = 1'b1;
        step(10);
        rd_digit(4'h7, 4'h9);
        rd_digit(4'h0, 4'h0);
        rd_digit(4'h5, 4'h8);
        report_and_stop;
    end
endmodule // testbench
